// *** aic_top.sv ***
// Analog input conditioning: scaling and filtering of two inputs, routing of the second input
`timescale 1ns/10ps
`default_nettype none
module aic_top #(
  parameter int unsigned TICK_CYC = aic_pkg::TICK_CYC
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire aic_pkg::aic_sample_t analog_input_one,
  input  wire aic_pkg::aic_sample_t analog_input_two,
  output logic signed [15:0]       analog_input_one_out,
  output logic signed [15:0]       analog_input_two_out,
  output logic      [4:0]          analog_input_two_func,
  output logic                     analog_input_two_route_valid,
  output logic                     result_update
);
  // Bus address phase
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] rdata_q;
  logic        hready_q;
  wire         addr_ph = hsel && htrans[1] && hready;
  wire         rd_take = addr_ph && !hwrite;
  wire  [7:0]  a_off   = haddr[7:0];

  // Configuration
  aic_pkg::aic_chan_cfg_t cfg_q [2];
  logic       range_q;
  logic       neg_q;
  logic [4:0] func_q;

  // Tick divider
  logic [15:0] tick_cnt_q;
  logic        tick_q;
  wire         tick_end = (tick_cnt_q == 16'(TICK_CYC - 1));

  // Write data clamped to documented ranges
  wire [13:0] wgain = (hwdata[31:14] != '0 || hwdata[13:0] > aic_pkg::GAIN_MAX) ?
                      aic_pkg::GAIN_MAX : hwdata[13:0];
  wire signed [31:0] wbias_full = $signed(hwdata);
  wire signed [15:0] wbias = (wbias_full > 32'(aic_pkg::BIAS_MAX)) ? aic_pkg::BIAS_MAX :
                             (wbias_full < 32'(aic_pkg::BIAS_MIN)) ? aic_pkg::BIAS_MIN : hwdata[15:0];
  wire [7:0]  wtau  = (hwdata[31:8] != '0 || hwdata[7:0] > aic_pkg::TAU_MAX) ?
                      aic_pkg::TAU_MAX : hwdata[7:0];
  wire        wr_now = wr_pend_q;

  // Per-channel data path
  logic [11:0]        code_q [2];
  logic [11:0]        x_norm [2];
  logic signed [15:0] lin    [2];
  logic signed [15:0] target [2];
  logic signed [47:0] acc_q  [2];
  logic signed [15:0] out_q  [2];
  logic [16:0]        alpha  [2];

  // Second input live-zero span
  wire [11:0] live_off = (code_q[1] > aic_pkg::LIVE_ZERO) ? (code_q[1] - aic_pkg::LIVE_ZERO) : 12'h000;
  wire [13:0] live_x   = 14'((15'(live_off) * 15'h5) >> 2);
  assign x_norm[0] = code_q[0];
  assign x_norm[1] = range_q ? ((live_x > 14'(aic_pkg::ADC_FS)) ? aic_pkg::ADC_FS : live_x[11:0])
                             : code_q[1];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      wire signed [16:0] span = $signed({3'b000, cfg_q[g].gain}) - 17'(cfg_q[g].bias);
      wire signed [31:0] prod = 32'(span) * $signed({20'h00000, x_norm[g]});
      wire signed [31:0] step = prod / $signed({20'h00000, aic_pkg::ADC_FS});
      assign lin[g]    = 16'(32'(cfg_q[g].bias) + step);
      assign target[g] = neg_q ? -lin[g] : lin[g];
      // Gain per tick is tick/tau, tau in 10 ms steps
      assign alpha[g]  = (cfg_q[g].tau == 8'h00) ? aic_pkg::ALPHA_ONE :
                         17'(aic_pkg::ALPHA_ONE / (17'(cfg_q[g].tau) * 17'(aic_pkg::TAU_STEP_TICKS)));
      wire signed [47:0] err  = $signed({target[g], 16'h0000}) - acc_q[g];
      wire signed [47:0] corr = 48'((64'(err) * $signed({47'h0, alpha[g]})) >>> 16);

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          code_q[g] <= 12'h000;
          acc_q[g]  <= '0;
          out_q[g]  <= 16'sh0000;
        end else begin
          if (g == 0 ? analog_input_one.valid : analog_input_two.valid) begin
            code_q[g] <= (g == 0) ? analog_input_one.code : analog_input_two.code;
          end
          if (tick_q) begin
            acc_q[g] <= acc_q[g] + corr;
          end
          out_q[g] <= 16'(acc_q[g] >>> 16);
        end
      end

      AST_GAIN_FS : assert property (@(posedge hclk) disable iff (!hresetn)
        (x_norm[g] == aic_pkg::ADC_FS) |-> (lin[g] == $signed({2'b00, cfg_q[g].gain})))
        else $error("full scale not at gain");
      AST_BIAS_ZERO : assert property (@(posedge hclk) disable iff (!hresetn)
        (x_norm[g] == 12'h000) |-> (lin[g] == cfg_q[g].bias))
        else $error("zero point not at bias");
      AST_NEG_SIGN : assert property (@(posedge hclk) disable iff (!hresetn)
        (neg_q && x_norm[g] == aic_pkg::ADC_FS) |-> (target[g] == -$signed({2'b00, cfg_q[g].gain})))
        else $error("negative characteristic wrong");
      AST_FILTER_PASS : assert property (@(posedge hclk) disable iff (!hresetn)
        (tick_q && cfg_q[g].tau == 8'h00) |-> ##2 (out_q[g] == $past(target[g], 2)))
        else $error("zero time constant not passthrough");
    end
  endgenerate

  // Register read mux
  wire [31:0] rd_mux =
    (a_off == aic_pkg::REG_CTRL)  ? {19'h0, func_q, 6'h0, neg_q, range_q} :
    (a_off == aic_pkg::REG_GAIN1) ? {18'h0, cfg_q[0].gain} :
    (a_off == aic_pkg::REG_BIAS1) ? 32'(cfg_q[0].bias) :
    (a_off == aic_pkg::REG_FILT1) ? {24'h0, cfg_q[0].tau} :
    (a_off == aic_pkg::REG_GAIN2) ? {18'h0, cfg_q[1].gain} :
    (a_off == aic_pkg::REG_BIAS2) ? 32'(cfg_q[1].bias) :
    (a_off == aic_pkg::REG_FILT2) ? {24'h0, cfg_q[1].tau} :
    (a_off == aic_pkg::REG_OUT1)  ? 32'(out_q[0]) :
    (a_off == aic_pkg::REG_OUT2)  ? 32'(out_q[1]) : 32'h0000_0000;

  wire route_ok = (func_q <= aic_pkg::FUNC_MAX) && (func_q != aic_pkg::FUNC_RSV_A)
                  && (func_q != aic_pkg::FUNC_RSV_B);

  // Bus phases
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q   <= 32'h0000_0000;
      hready_q  <= 1'b1;
    end else begin
      wr_pend_q <= addr_ph && hwrite;
      if (addr_ph) begin
        wr_addr_q <= a_off;
      end
      if (rd_take) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Configuration writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      range_q <= 1'b0;
      neg_q   <= 1'b0;
      func_q  <= aic_pkg::FUNC_RST;
      for (int i = 0; i < 2; i++) begin
        cfg_q[i] <= '{gain: aic_pkg::GAIN_RST, bias: aic_pkg::BIAS_RST, tau: aic_pkg::TAU_RST};
      end
    end else if (wr_now) begin
      case (wr_addr_q)
        aic_pkg::REG_CTRL: begin
          range_q <= hwdata[aic_pkg::CTRL_RANGE_BIT];
          neg_q   <= hwdata[aic_pkg::CTRL_NEG_BIT];
          func_q  <= hwdata[aic_pkg::CTRL_FUNC_LSB +: 5];
        end
        aic_pkg::REG_GAIN1: cfg_q[0].gain <= wgain;
        aic_pkg::REG_BIAS1: cfg_q[0].bias <= wbias;
        aic_pkg::REG_FILT1: cfg_q[0].tau  <= wtau;
        aic_pkg::REG_GAIN2: cfg_q[1].gain <= wgain;
        aic_pkg::REG_BIAS2: cfg_q[1].bias <= wbias;
        aic_pkg::REG_FILT2: cfg_q[1].tau  <= wtau;
        default: begin
        end
      endcase
    end
  end

  // Tick divider and outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q  <= 16'h0000;
      tick_q      <= 1'b0;
      analog_input_two_func        <= aic_pkg::FUNC_RST;
      analog_input_two_route_valid <= 1'b0;
      result_update                <= 1'b0;
    end else begin
      tick_cnt_q <= tick_end ? 16'h0000 : tick_cnt_q + 16'h0001;
      tick_q     <= tick_end;
      analog_input_two_func        <= func_q;
      analog_input_two_route_valid <= route_ok;
      result_update                <= tick_q;
    end
  end

  assign hrdata               = rdata_q;
  assign hreadyout            = hready_q;
  assign hresp                = 1'b0;
  assign analog_input_one_out = out_q[0];
  assign analog_input_two_out = out_q[1];

  AST_RANGE_FULL : assert property (@(posedge hclk) disable iff (!hresetn)
    !range_q |-> (x_norm[1] == code_q[1]))
    else $error("full span not passed through");
  AST_RANGE_LIVE : assert property (@(posedge hclk) disable iff (!hresetn)
    (range_q && code_q[1] <= aic_pkg::LIVE_ZERO) |-> (x_norm[1] == 12'h000))
    else $error("live zero offset wrong");
  AST_ROUTE_RSV : assert property (@(posedge hclk) disable iff (!hresetn)
    (func_q == aic_pkg::FUNC_RSV_A || func_q == aic_pkg::FUNC_RSV_B) |=> !analog_input_two_route_valid)
    else $error("reserved code routed");
  AST_ROUTE_OK : assert property (@(posedge hclk) disable iff (!hresetn)
    (func_q == 5'h10) |=> (analog_input_two_route_valid && analog_input_two_func == 5'h10))
    else $error("valid code not routed");
  AST_GAIN_INDEP : assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_now && wr_addr_q == aic_pkg::REG_GAIN1) |=> $stable(cfg_q[1].gain))
    else $error("gain write leaked to other input");
  AST_TICK_HOLD : assert property (@(posedge hclk) disable iff (!hresetn)
    tick_q |=> !tick_q)
    else $error("tick longer than one cycle");
endmodule
`default_nettype wire

// *** aic_pkg.sv ***
// Package for the analog input conditioning block
package aic_pkg;
  localparam int unsigned CLK_MHZ      = 10;
  localparam int unsigned TICK_TIME_US = 1000;
  localparam int unsigned TICK_CYC     = TICK_TIME_US * CLK_MHZ;
  // Filter time register counts 10 ms steps, filter runs at one tick per ms
  localparam int unsigned TAU_STEP_TICKS = 10;
  localparam logic [16:0] ALPHA_ONE    = 17'h10000;
  localparam logic [7:0]  TAU_MAX      = 8'hC8;
  localparam logic [13:0] GAIN_MAX     = 14'h2710;
  localparam logic signed [15:0] BIAS_MAX = 16'sh03E8;
  localparam logic signed [15:0] BIAS_MIN = -16'sh03E8;
  localparam logic [11:0] ADC_FS       = 12'hFFF;
  localparam logic [11:0] LIVE_ZERO    = 12'h333;
  localparam logic [4:0]  FUNC_RSV_A   = 5'h0F;
  localparam logic [4:0]  FUNC_RSV_B   = 5'h11;
  localparam logic [4:0]  FUNC_MAX     = 5'h11;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_GAIN1 = 8'h04;
  localparam logic [7:0] REG_BIAS1 = 8'h08;
  localparam logic [7:0] REG_FILT1 = 8'h0C;
  localparam logic [7:0] REG_GAIN2 = 8'h10;
  localparam logic [7:0] REG_BIAS2 = 8'h14;
  localparam logic [7:0] REG_FILT2 = 8'h18;
  localparam logic [7:0] REG_OUT1  = 8'h1C;
  localparam logic [7:0] REG_OUT2  = 8'h20;
  // CTRL fields
  localparam int unsigned CTRL_RANGE_BIT = 0;
  localparam int unsigned CTRL_NEG_BIT   = 1;
  localparam int unsigned CTRL_FUNC_LSB  = 8;
  // Reset values
  localparam logic [13:0] GAIN_RST = 14'h03E8;
  localparam logic signed [15:0] BIAS_RST = 16'sh0000;
  localparam logic [7:0]  TAU_RST  = 8'h0A;
  localparam logic [4:0]  FUNC_RST = 5'h00;

  typedef struct packed {
    logic [13:0]        gain;
    logic signed [15:0] bias;
    logic [7:0]         tau;
  } aic_chan_cfg_t;

  typedef struct packed {
    logic [11:0] code;
    logic        valid;
  } aic_sample_t;
endpackage

// *** aic_adc_model.sv ***
// Converter model driving both sample inputs
`timescale 1ns/10ps
`default_nettype none
module aic_adc_model (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic [11:0]     code_one,
  input  wire logic [11:0]     code_two,
  output var aic_pkg::aic_sample_t smp_one,
  output var aic_pkg::aic_sample_t smp_two
);
  logic [1:0] div_q;
  logic       strobe;
  // Code is good only with valid, inverted between samples
  assign strobe = (div_q == 2'h3);
  assign smp_one = '{code: strobe ? code_one : ~code_one, valid: strobe};
  assign smp_two = '{code: strobe ? code_two : ~code_two, valid: strobe};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) div_q <= 2'h0;
    else div_q <= div_q + 2'h1;
  end
endmodule
`default_nettype wire

// *** aic_top_tb.sv ***
// Testbench for the analog input conditioning block
`timescale 1ns/10ps
`default_nettype none
module aic_top_tb;
  logic        hclk = 1'b0;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  wire logic   hready;
  logic [11:0] code_one;
  logic [11:0] code_two;
  aic_pkg::aic_sample_t smp_one;
  aic_pkg::aic_sample_t smp_two;
  logic signed [15:0] out1;
  logic signed [15:0] out2;
  logic [4:0]  func;
  logic        rvalid;
  logic        upd;
  int          failures = 0;
  int          compares = 0;
  assign hready = hreadyout;
  always #50 hclk = ~hclk;
  aic_adc_model adc (.hclk(hclk), .hresetn(hresetn), .code_one(code_one), .code_two(code_two),
    .smp_one(smp_one), .smp_two(smp_two));
  aic_top #(.TICK_CYC(20)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .analog_input_one(smp_one),
    .analog_input_two(smp_two), .analog_input_one_out(out1), .analog_input_two_out(out2),
    .analog_input_two_func(func), .analog_input_two_route_valid(rvalid), .result_update(upd));
  task automatic finish_test();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_ready();
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check(32'(hresp), 32'h0);
    @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    xfer(1'b1, a, d, rd);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    xfer(1'b0, a, 32'h0, rd);
    check(rd, exp);
  endtask
  task automatic steps(input int n);
    repeat (n) do @(posedge hclk); while (upd !== 1'b1);
    // Last step reaches the outputs one edge later
    @(posedge hclk);
  endtask
  function automatic logic signed [15:0] lin(input int g, input int b, input int x);
    return 16'(b + (g - b) * x / 4095);
  endfunction
  task automatic apply(input logic [11:0] c1, input logic [11:0] c2, input logic signed [15:0] e1,
                       input logic signed [15:0] e2);
    code_one <= c1;
    code_two <= c2;
    steps(3);
    check(32'(out1), 32'(e1));
    check(32'(out2), 32'(e2));
  endtask
  task automatic t_reset();
    check(32'(rvalid), 32'h1);
    rd_chk(aic_pkg::REG_CTRL, 32'h0);
    rd_chk(aic_pkg::REG_GAIN1, 32'h3E8);
    rd_chk(aic_pkg::REG_FILT2, 32'h0A);
    rd_chk(8'h40, 32'h0);
    wr(aic_pkg::REG_GAIN1, 32'h3FFF);
    rd_chk(aic_pkg::REG_GAIN1, 32'h2710);
    wr(aic_pkg::REG_FILT1, 32'hFF);
    rd_chk(aic_pkg::REG_FILT1, 32'hC8);
  endtask
  task automatic t_scale();
    wr(aic_pkg::REG_FILT1, 32'h0);
    wr(aic_pkg::REG_FILT2, 32'h0);
    wr(aic_pkg::REG_GAIN1, 32'd2000);
    wr(aic_pkg::REG_BIAS1, -32'sd100);
    wr(aic_pkg::REG_GAIN2, 32'd500);
    wr(aic_pkg::REG_BIAS2, 32'd300);
    apply(12'hFFF, 12'h000, 16'sd2000, 16'sd300);
    apply(12'h000, 12'hFFF, -16'sd100, 16'sd500);
    apply(12'h800, 12'h400, lin(2000, -100, 2048), lin(500, 300, 1024));
    wr(aic_pkg::REG_CTRL, 32'h1);
    apply(12'h333, 12'h333, lin(2000, -100, 819), 16'sd300);
    apply(12'h000, 12'h100, -16'sd100, 16'sd300);
    apply(12'hFFF, 12'hFFF, 16'sd2000, 16'sd500);
    wr(aic_pkg::REG_CTRL, 32'h2);
    apply(12'hFFF, 12'h000, -16'sd2000, -16'sd300);
    wr(aic_pkg::REG_CTRL, 32'h0);
  endtask
  task automatic t_filter();
    wr(aic_pkg::REG_GAIN1, 32'd1000);
    wr(aic_pkg::REG_BIAS1, 32'd0);
    apply(12'h000, 12'h000, 16'sd0, 16'sd300);
    wr(aic_pkg::REG_FILT1, 32'h1);
    code_one <= 12'hFFF;
    steps(10);
    check(32'(out1 >= 600 && out1 <= 700), 32'h1);
    check(32'(out2), 32'sd300);
    steps(40);
    check(32'(out1 > 950), 32'h1);
  endtask
  task automatic t_route();
    for (int f = 0; f <= 18; f++) begin
      wr(aic_pkg::REG_CTRL, 32'(f) << 8);
      repeat (2) @(posedge hclk);
      check(32'(func), 32'(f));
      check(32'(rvalid), 32'(f != 15 && f < 17));
    end
  endtask
  initial begin
    #2_000_000;
    failures++;
    finish_test();
  end
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata, code_one, code_two} = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_reset();
    t_scale();
    t_filter();
    t_route();
    finish_test();
  end
endmodule
`default_nettype wire
